// file: adc_device.sv
// Converter end: frames, shifts out results and handles power-down.
// Assumes csN and sclk are synchronous to clk_sys and slower than it.
`timescale 1ns/1ps
`default_nettype none
`include "adc_link_defs.svh"

module adc_device
  import adc_link_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link
  adc_link_if.device link,
  // Converter core side
  input wire code_t sampleIn,
  input wire logic fourteenMode,
  // Status
  output logic sampleTaken,
  output logic frameDone,
  output logic poweredDown
);

  typedef enum {IDLE, CONV} dstate_t;

  // Pin history for edge detection
  logic sclkPrev_r, sclkPrev_nxt;
  logic csPrev_r, csPrev_nxt;
  logic sclkFall, csFall, csRise;

  // Frame control and fall counter
  dstate_t state_r, state_nxt;
  logic asleep_r, asleep_nxt;
  logic dummy_r, dummy_nxt;
  fallcnt_t fallCnt_r, fallCnt_nxt;
  fallcnt_t nextCnt;
  logic frameStart, frameEnd, frameAbort, fallStep;

  // Data path
  code_t sar_r, sar_nxt;
  logic dout_r, dout_nxt;
  logic oe_r, oe_nxt;

  // Status pulses
  logic take_r, take_nxt;
  logic done_r, done_nxt;

  always_comb begin
    sclkPrev_nxt = link.sclk;
    csPrev_nxt = link.csN;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclkPrev_r <= `SCLK_IDLE;
      csPrev_r <= 1'b1;
    end else begin
      sclkPrev_r <= sclkPrev_nxt;
      csPrev_r <= csPrev_nxt;
    end
  end

  assign sclkFall = sclkPrev_r & ~link.sclk;
  assign csFall = csPrev_r & ~link.csN;
  assign csRise = ~csPrev_r & link.csN;
  assign nextCnt = fallCnt_r + 5'h01;
  // A select edge wins over a clock fall seen in the same cycle
  assign frameStart = (state_r == IDLE) & csFall;
  assign frameEnd = (state_r == CONV) & csRise;
  assign frameAbort = frameEnd & (fallCnt_r < `MODE_FALL);
  // Falls beyond a full frame are not counted
  assign fallStep = (state_r == CONV) & ~csRise & sclkFall & (fallCnt_r != `FRAME_FALLS);

  always_comb begin
    state_nxt = state_r;
    asleep_nxt = asleep_r;
    dummy_nxt = dummy_r;
    case (state_r)
      IDLE: begin
        if (frameStart) begin
          state_nxt = CONV;
          dummy_nxt = asleep_r;
        end
      end
      CONV: begin
        if (frameEnd) begin
          state_nxt = IDLE;
          // Passing the mode fall wakes the core
          asleep_nxt = frameAbort;
        end
      end
      default: begin
        state_nxt = IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= IDLE;
      asleep_r <= 1'b0;
      dummy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      asleep_r <= asleep_nxt;
      dummy_r <= dummy_nxt;
    end
  end

  always_comb begin
    fallCnt_nxt = fallCnt_r;
    if (frameStart) begin
      fallCnt_nxt = '0;
    end else if (fallStep) begin
      fallCnt_nxt = nextCnt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fallCnt_r <= '0;
    end else begin
      fallCnt_r <= fallCnt_nxt;
    end
  end

  always_comb begin
    sar_nxt = sar_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    case (state_r)
      IDLE: begin
        if (frameStart) begin
          sar_nxt = sampleIn;
          dout_nxt = 1'b0;
          oe_nxt = 1'b1;
        end
      end
      CONV: begin
        if (frameAbort) begin
          oe_nxt = 1'b0;
        end else if (frameEnd) begin
          // Held driven only in fourteen-clock mode, else released
          oe_nxt = fourteenMode & oe_r;
          dout_nxt = 1'b0;
        end else if (fallStep) begin
          if (nextCnt <= `LAST_DATA_FALL) begin
            // Asleep core yields zeros; the dummy frame's data is invalid
            dout_nxt = sar_r[`RES_BITS-1] & ~dummy_r;
            sar_nxt = {sar_r[`RES_BITS-2:0], 1'b0};
          end else begin
            dout_nxt = 1'b0;
          end
          if (nextCnt == `RELEASE_FALL) begin
            oe_nxt = 1'b0;
          end
        end
      end
      default: begin
        oe_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sar_r <= '0;
      dout_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      sar_r <= sar_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
    end
  end

  always_comb begin
    take_nxt = frameStart;
    done_nxt = frameEnd & ~frameAbort & ~dummy_r;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      take_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      take_r <= take_nxt;
      done_r <= done_nxt;
    end
  end

  assign link.dout = dout_r;
  assign link.doutOe = oe_r;
  assign sampleTaken = take_r;
  assign frameDone = done_r;
  assign poweredDown = asleep_r;

endmodule // adc_device

`default_nettype wire

// file: adc_host.sv
// Host end: drives select and a divided serial clock, collects results.
// Assumes the far end follows the converter framing on the same link.
`timescale 1ns/1ps
`default_nettype none
`include "adc_link_defs.svh"

module adc_host
  import adc_link_pkg::*;
#(
  parameter logic [`DIV_W-1:0] HALF_DIV = `HALF_DIV
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link
  adc_link_if.host link,
  // User side
  input wire logic startReq,
  input wire logic powerDownReq,
  input wire logic fourteenMode,
  output logic busy,
  output logic resultValid,
  output code_t result,
  output logic resultStale
);

  typedef enum {IDLE, SETUP, RUN, GAP} hstate_t;

  hstate_t state_r, state_nxt;
  logic [`DIV_W-1:0] div_r, div_nxt;
  fallcnt_t falls_r, falls_nxt;
  logic sclk_r, sclk_nxt;
  logic cs_r, cs_nxt;
  logic pd_r, pd_nxt;
  logic asleep_r, asleep_nxt;
  logic wake_r, wake_nxt;
  code_t shift_r, shift_nxt;
  code_t res_r, res_nxt;
  logic valid_r, valid_nxt;
  logic stale_r, stale_nxt;
  logic tick;
  fallcnt_t cycleNo, endFall;

  // One divider serves every half period of the serial clock
  assign tick = (div_r == HALF_DIV - 8'h01);
  assign cycleNo = falls_r + 5'h01;
  assign endFall = fourteenMode ? `FRAME14_FALLS : `FRAME_FALLS;

  always_comb begin
    state_nxt = state_r;
    div_nxt = (state_r == IDLE || tick) ? '0 : div_r + 8'h01;
    falls_nxt = falls_r;
    sclk_nxt = sclk_r;
    cs_nxt = cs_r;
    pd_nxt = pd_r;
    asleep_nxt = asleep_r;
    wake_nxt = wake_r;
    shift_nxt = shift_r;
    res_nxt = res_r;
    valid_nxt = 1'b0;
    stale_nxt = stale_r;
    case (state_r)
      IDLE: begin
        if (startReq) begin
          state_nxt = SETUP;
          cs_nxt = 1'b0;
          falls_nxt = '0;
          pd_nxt = powerDownReq & ~asleep_r;
          wake_nxt = asleep_r;
        end
      end
      SETUP: begin
        if (tick) begin
          state_nxt = RUN;
        end
      end
      RUN: begin
        if (tick) begin
          sclk_nxt = ~sclk_r;
          if (!sclk_r) begin
            if (cycleNo >= `FIRST_DATA_RISE && cycleNo <= `LAST_DATA_RISE) begin
              shift_nxt = {shift_r[`RES_BITS-2:0], link.dout};
            end
          end else begin
            falls_nxt = cycleNo;
            if (pd_r && cycleNo == `PD_ABORT_FALL) begin
              cs_nxt = 1'b1;
              asleep_nxt = 1'b1;
              state_nxt = GAP;
            end else if (cycleNo == endFall) begin
              cs_nxt = 1'b1;
              asleep_nxt = 1'b0;
              res_nxt = shift_r;
              valid_nxt = 1'b1;
              stale_nxt = wake_r;
              state_nxt = GAP;
            end
          end
        end
      end
      GAP: begin
        // Shortest legal gap keeps the full sample rate
        if (tick) begin
          state_nxt = IDLE;
        end
      end
      default: begin
        state_nxt = IDLE;
        cs_nxt = 1'b1;
        sclk_nxt = `SCLK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= IDLE;
      div_r <= '0;
      falls_r <= '0;
      sclk_r <= `SCLK_IDLE;
      cs_r <= 1'b1;
      pd_r <= 1'b0;
      asleep_r <= 1'b0;
      wake_r <= 1'b0;
      shift_r <= '0;
      res_r <= '0;
      valid_r <= 1'b0;
      stale_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      div_r <= div_nxt;
      falls_r <= falls_nxt;
      sclk_r <= sclk_nxt;
      cs_r <= cs_nxt;
      pd_r <= pd_nxt;
      asleep_r <= asleep_nxt;
      wake_r <= wake_nxt;
      shift_r <= shift_nxt;
      res_r <= res_nxt;
      valid_r <= valid_nxt;
      stale_r <= stale_nxt;
    end
  end

  assign link.csN = cs_r;
  assign link.sclk = sclk_r;
  assign busy = (state_r != IDLE);
  assign resultValid = valid_r;
  assign result = res_r;
  assign resultStale = stale_r;

endmodule // adc_host

`default_nettype wire

// file: adc_link_chk.sv
// Checker on the shared link wires between host and converter.
// Assumes both ends sit on one link; bench instantiates it beside it.
`timescale 1ns/1ps
`default_nettype none

module adc_link_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link wires
  input wire logic csN,
  input wire logic sclk,
  input wire logic dout,
  input wire logic doutOe
);
  logic sclkPrev_r;
  logic csPrev_r;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic fellSclk;
  logic [4:0] cntNow;

  // Fall counted in the same cycle it is seen
  assign fellSclk = sclkPrev_r & ~sclk;
  assign cntNow = cnt_r + {4'h0, fellSclk};

  always_comb begin
    cnt_nxt = cntNow;
    if (csPrev_r & ~csN) begin
      cnt_nxt = 5'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclkPrev_r <= 1'b0;
      csPrev_r <= 1'b1;
      cnt_r <= 5'h00;
    end else begin
      sclkPrev_r <= sclk;
      csPrev_r <= csN;
      cnt_r <= cnt_nxt;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_LEAD_ZERO: assert property ($fell(csN) |-> ##2 doutOe && !dout)
    else $error("no leading zero after select fall");
  AST_OE_CAUSE: assert property ($rose(doutOe) |-> $past(csN, 2) && !$past(csN))
    else $error("data driven without a select fall");
  AST_DOUT_EDGE: assert property (doutOe && $past(doutOe) && $changed(dout) |-> $past(fellSclk))
    else $error("data changed off a clock fall");
  AST_TRAIL_ZERO: assert property (fellSclk && (cnt_r == 5'd12 || cnt_r == 5'd13) |-> ##2 !dout)
    else $error("trailing bit not zero");
  AST_RELEASE: assert property (fellSclk && cnt_r == 5'd14 |-> ##2 !doutOe)
    else $error("data not released in cycle sixteen");
  AST_ABORT_PD: assert property ($rose(csN) && cntNow < 5'd10 |-> ##2 !doutOe)
    else $error("early select rise kept data driven");
  AST_FRAME_LEN: assert property ($rose(csN) |-> cntNow == 5'd3 || cntNow == 5'd14 || cntNow == 5'd16)
    else $error("frame ended on odd fall count");
  AST_SCLK_IDLE: assert property (csN |-> !sclk)
    else $error("clock moved outside a frame");
endmodule // adc_link_chk

`default_nettype wire

// file: adc_link_defs.svh
// Shared constants of the serial converter link.
// Included by the package and both ends; holds macros only.
`ifndef ADC_LINK_DEFS_SVH
`define ADC_LINK_DEFS_SVH

`define RES_BITS 12
`define CNT_W 5
`define FRAME_FALLS 5'h10
`define FRAME14_FALLS 5'h0e
`define LAST_DATA_FALL 5'h0c
`define RELEASE_FALL 5'h0f
`define MODE_FALL 5'h0a
`define PD_ABORT_FALL 5'h03
`define FIRST_DATA_RISE 5'h02
`define LAST_DATA_RISE 5'h0d
`define HALF_DIV 8'h03
`define DIV_W 8
`define SCLK_IDLE 1'b0

`endif

// file: adc_link_if.sv
// Three-wire link between host controller and converter.
// The host samples dout on its data rises without looking at doutOe.
`timescale 1ns/1ps
`default_nettype none

interface adc_link_if;
  logic csN;
  logic sclk;
  logic dout;
  logic doutOe;
  modport device (input csN, input sclk, output dout, output doutOe);
  modport host (output csN, output sclk, input dout, input doutOe);
endinterface

`default_nettype wire

// file: adc_link_pkg.sv
// Types shared by both ends of the converter link.
// Assumes adc_link_defs.svh is on the include path.
`include "adc_link_defs.svh"

package adc_link_pkg;
  typedef logic [`RES_BITS-1:0] code_t;
  typedef logic [`CNT_W-1:0] fallcnt_t;
endpackage

// file: serial_adc_frame_interface_bench.sv
// Bench joining host and converter ends over one link.
// Assumes design files and the link checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module serial_adc_frame_interface_bench
  import adc_link_pkg::*;
;
  logic clk_sys;
  logic rst_n;
  code_t sampleIn;
  code_t result;
  logic fourteenMode, startReq, powerDownReq;
  logic sampleTaken, frameDone, poweredDown, busy, resultValid, resultStale;
  int bad_count = 0;
  int comparisons = 0;
  code_t codes [4] = '{12'h000, 12'hfff, 12'ha5c, 12'h801};

  adc_link_if link();
  adc_device adc_device_inst (.clk_sys, .rst_n, .link(link.device), .sampleIn, .fourteenMode,
    .sampleTaken, .frameDone, .poweredDown);
  // Smaller divider keeps the run short
  adc_host #(.HALF_DIV(8'h02)) adc_host_inst (.clk_sys, .rst_n, .link(link.host), .startReq,
    .powerDownReq, .fourteenMode, .busy, .resultValid, .result, .resultStale);
  adc_link_chk adc_link_chk_inst (.clk_sys, .rst_n, .csN(link.csN), .sclk(link.sclk),
    .dout(link.dout), .doutOe(link.doutOe));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One frame; stale only counts when it comes with a result
  task automatic run(input code_t c, input logic pd, fm, st);
    int n;
    logic [3:0] got;
    @(posedge clk_sys);
    sampleIn <= c;
    powerDownReq <= pd;
    fourteenMode <= fm;
    startReq <= 1'b1;
    @(posedge clk_sys);
    startReq <= 1'b0;
    n = 0;
    got = 4'h0;
    do begin
      @(posedge clk_sys);
      #1;
      got |= {sampleTaken, resultValid, resultValid & resultStale, frameDone};
      n++;
    end while (busy !== 1'b0 && n < 600);
    repeat (4) begin
      @(posedge clk_sys);
      #1;
      got |= {sampleTaken, resultValid, resultValid & resultStale, frameDone};
    end
    chk(busy, 1'b0);
    chk(got[3], 1'b1);
    chk(got[2], !pd);
    chk(poweredDown, pd);
    chk(link.doutOe, fm & !pd);
    if (!pd) begin
      chk(got[1], st);
      chk(got[0], !st);
    end
    if (!pd && !st) begin
      chk(result, c);
    end
  endtask

  initial begin
    rst_n = 1'b0;
    sampleIn = 12'h000;
    fourteenMode = 1'b0;
    startReq = 1'b0;
    powerDownReq = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (codes[i]) run(codes[i], 1'b0, 1'b0, 1'b0);
    run(12'h3c7, 1'b0, 1'b1, 1'b0);
    run(12'h5a5, 1'b0, 1'b0, 1'b0);
    run(12'h0f0, 1'b1, 1'b0, 1'b0);
    run(12'h123, 1'b0, 1'b0, 1'b1);
    run(12'hedb, 1'b0, 1'b0, 1'b0);
    final_report;
  end

  // Whole run needs a few microseconds
  initial begin
    #40000;
    bad_count++;
    final_report;
  end
endmodule // serial_adc_frame_interface_bench

`default_nettype wire
